/* hw/gatr_core.sv */
// Alarm evaluation core: two alarm levels, relay drive, flow supervision,
// maintenance and calibration suppression, register port and interrupt.
// Assumes concentration and flow words come from logic on the same clock;
// relay module presence and acknowledge key arrive from pins.
//
// Overview of operation
// - Monitoring off suppresses both level alarm outputs outside test modes and raises a warning.
// - Each level trips rising or falling per its direction bit.
// - Latching alarm stays active after clearing until acknowledged.
// - Non-latching alarm releases itself once the condition clears.
// - Acknowledgeable alarm clears on acknowledge even with condition present.
// - Non-acknowledgeable alarm ignores acknowledge while condition holds.
// - Alarm asserts as soon as concentration reaches the set point.
// - Tripped rising alarm releases only below set point minus hysteresis.
// - Relay and digital alarm outputs driven only with relay module present.
// - Relays energised when normal, de-energised to signal alarm.
// - Flow below 0.3 L/min gives fault, below 0.4 L/min warning.
// - Pump adjustment outputs maintenance signal and suppresses the flow fault and warning.
// - Autocalibration runs zero then span, maintenance signal throughout.
// - Without autostability, stability is detected and span completes alone.
// - Second level has the same options as the first.
// - Global acknowledge disable blocks every acknowledge.
// - Test modes force relays and interfaces into the chosen state.
// - Calibration keeps alarm and fault relays from switching unless any test mode is set.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module gatr_core
  import gatr_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  input wire logic [CONC_W-1:0] conc,
  input wire logic [FLOW_W-1:0] flow,
  input wire logic relayPresentPin,
  input wire logic ackKeyPin,
  input wire logic acceptKeyPin,
  output logic relayLvl1,
  output logic relayLvl2,
  output logic relayFault,
  output logic [2:0] digAlarm,
  output logic maintSignal,
  output logic monitorWarn,
  output logic flowFault,
  output logic flowWarn,
  output logic calZeroStep,
  output logic calSpanStep,
  output logic irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic relayPresent;
  logic ackKey;
  logic acceptKey;
  logic ackKeyOld;
  logic acceptKeyOld;
  logic ackPulse;
  logic acceptPulse;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      syncA <= 3'h0;
      syncB <= 3'h0;
    end
    else
    begin
      syncA <= {acceptKeyPin, ackKeyPin, relayPresentPin};
      syncB <= syncA;
    end
  end

  assign relayPresent = syncB[0];
  assign ackKey = syncB[1];
  assign acceptKey = syncB[2];

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ackKeyOld <= 1'b0;
      acceptKeyOld <= 1'b0;
    end
    else
    begin
      ackKeyOld <= ackKey;
      acceptKeyOld <= acceptKey;
    end
  end

  logic [CTRL_W-1:0] ctrl;
  logic swAck;
  assign ackPulse = ((ackKey && !ackKeyOld) || swAck) && !ctrl[CTRL_ACK_DIS];
  assign acceptPulse = acceptKey && !acceptKeyOld;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] lvl1;
  logic [DATA_W-1:0] lvl2;
  logic [5:0] cfg;
  logic [IRQ_W-1:0] istat;
  logic [IRQ_W-1:0] imask;
  logic [IRQ_W-1:0] events;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrl <= CTRL_RESET;
      lvl1 <= '0;
      lvl2 <= '0;
      cfg <= {CFG_RESET, CFG_RESET};
      imask <= '0;
    end
    else if (regWrite)
    begin
      case (regAddr)
        REG_CTRL: ctrl <= regWrData[CTRL_W-1:0];
        REG_LVL1: lvl1 <= regWrData;
        REG_LVL2: lvl2 <= regWrData;
        REG_CFG: cfg <= regWrData[5:0];
        REG_IMASK: imask <= regWrData[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign swAck = regWrite && (regAddr == REG_ACK) && regWrData[0];

  // ----------------------------------------------------------------
  // Alarm levels
  // ----------------------------------------------------------------
  logic trip1;
  logic trip2;
  logic act1;
  logic act2;

  gatr_level u_lvl1
  (
    .clock(clock),
    .reset(reset),
    .conc(conc),
    .setPoint(lvl1[15:0]),
    .hyst(lvl1[31:16]),
    .falling(cfg[CFG_FALL]),
    .latching(cfg[CFG_LATCH]),
    .ackable(cfg[CFG_ACKABLE]),
    .ackPulse(ackPulse),
    .tripped(trip1),
    .active(act1)
  );

  // Same option set as the first level
  gatr_level u_lvl2
  (
    .clock(clock),
    .reset(reset),
    .conc(conc),
    .setPoint(lvl2[15:0]),
    .hyst(lvl2[31:16]),
    .falling(cfg[3 + CFG_FALL]),
    .latching(cfg[3 + CFG_LATCH]),
    .ackable(cfg[3 + CFG_ACKABLE]),
    .ackPulse(ackPulse),
    .tripped(trip2),
    .active(act2)
  );

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  gatr_cal_e calState;
  logic [31:0] stabCount;
  logic [CONC_W-1:0] stabRef;
  logic stable;
  logic calRun;

  assign stable = (stabCount >= 32'(STAB_COUNT));

  always_ff @(posedge clock)
  begin
    if (reset)
      calState <= CAL_IDLE;
    else
    begin
      case (calState)
        CAL_IDLE:
          if (ctrl[CTRL_AUTOCAL])
            calState <= CAL_ZERO;
        CAL_ZERO:
          if (acceptPulse)
            calState <= CAL_SPAN;
        CAL_SPAN:
          if (ctrl[CTRL_AUTOSTAB] ? acceptPulse : stable)
            calState <= CAL_DONE;
        CAL_DONE:
          if (!ctrl[CTRL_AUTOCAL])
            calState <= CAL_IDLE;
        default: calState <= CAL_IDLE;
      endcase
    end
  end

  // Stability: value stays inside a small band for the count
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      stabCount <= '0;
      stabRef <= '0;
    end
    else if (calState != CAL_SPAN || {1'b0, conc} > {1'b0, stabRef} + {1'b0, STAB_BAND}
      || {1'b0, stabRef} > {1'b0, conc} + {1'b0, STAB_BAND})
    begin
      stabCount <= '0;
      stabRef <= conc;
    end
    else if (!stable)
      stabCount <= stabCount + 32'h1;
  end

  assign calRun = (calState == CAL_ZERO) || (calState == CAL_SPAN)
    || ctrl[CTRL_CAL_ZERO] || ctrl[CTRL_CAL_SPAN];

  // ----------------------------------------------------------------
  // Output evaluation
  // ----------------------------------------------------------------
  logic monOn;
  logic alarm1;
  logic alarm2;
  logic faultState;
  logic next_relayLvl1;
  logic next_relayLvl2;
  logic next_relayFault;
  logic fFault;
  logic fWarn;

  assign monOn = ctrl[CTRL_MON_EN];
  assign fFault = (flow < FLOW_FAULT_MLMIN) && !ctrl[CTRL_PUMP_ADJ];
  assign fWarn = (flow < FLOW_WARN_MLMIN) && !ctrl[CTRL_PUMP_ADJ];
  assign alarm1 = ctrl[CTRL_TEST1] || (monOn && act1);
  assign alarm2 = ctrl[CTRL_TEST2] || (monOn && act2);
  assign faultState = ctrl[CTRL_TESTF] || fFault;

  // Energised (1) means no alarm
  always_comb
  begin
    next_relayLvl1 = relayLvl1;
    next_relayLvl2 = relayLvl2;
    next_relayFault = relayFault;
    if (!relayPresent)
    begin
      next_relayLvl1 = 1'b0;
      next_relayLvl2 = 1'b0;
      next_relayFault = 1'b0;
    end
    else if (!calRun || ctrl[CTRL_TEST1] || ctrl[CTRL_TEST2] || ctrl[CTRL_TESTF])
    begin
      next_relayLvl1 = !alarm1;
      next_relayLvl2 = !alarm2;
      next_relayFault = !faultState;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      relayLvl1 <= 1'b0;
      relayLvl2 <= 1'b0;
      relayFault <= 1'b0;
      digAlarm <= 3'h0;
    end
    else
    begin
      relayLvl1 <= next_relayLvl1;
      relayLvl2 <= next_relayLvl2;
      relayFault <= next_relayFault;
      digAlarm <= relayPresent ? {faultState, alarm2, alarm1} : 3'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      maintSignal <= 1'b0;
      monitorWarn <= 1'b0;
      flowFault <= 1'b0;
      flowWarn <= 1'b0;
      calZeroStep <= 1'b0;
      calSpanStep <= 1'b0;
    end
    else
    begin
      maintSignal <= ctrl[CTRL_PUMP_ADJ] || calRun;
      monitorWarn <= !monOn;
      flowFault <= fFault;
      flowWarn <= fWarn;
      calZeroStep <= calState == CAL_ZERO;
      calSpanStep <= calState == CAL_SPAN;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------------------------------
  assign events = {calState == CAL_SPAN && (ctrl[CTRL_AUTOSTAB] ? acceptPulse : stable),
    fWarn, fFault, alarm2, alarm1};

  always_ff @(posedge clock)
  begin
    if (reset)
      istat <= '0;
    else if (regWrite && regAddr == REG_ISTAT)
      istat <= (istat & ~regWrData[IRQ_W-1:0]) | events;
    else
      istat <= istat | events;
  end

  assign irq = |(istat & imask);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
      regRdData <= '0;
    else if (regRead)
    begin
      case (regAddr)
        REG_CTRL: regRdData <= {22'h0, ctrl};
        REG_LVL1: regRdData <= lvl1;
        REG_LVL2: regRdData <= lvl2;
        REG_CFG: regRdData <= {26'h0, cfg};
        REG_CONC: regRdData <= {16'h0, conc};
        REG_STAT: regRdData <= {23'h0, calState, relayPresent, fWarn, fFault, act2, act1, trip2, trip1};
        REG_ISTAT: regRdData <= {27'h0, istat};
        REG_IMASK: regRdData <= {27'h0, imask};
        default: regRdData <= '0;
      endcase
    end
    else
      regRdData <= '0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  monOff_a: assert property (@(posedge clock) disable iff (reset)
    !monOn && !ctrl[CTRL_TEST1] |=> digAlarm[0] == 1'b0 && monitorWarn)
    else $error("alarm shown while monitoring off");

  noModule_a: assert property (@(posedge clock) disable iff (reset)
    !relayPresent |=> relayLvl1 == 1'b0 && digAlarm == 3'h0)
    else $error("outputs driven without relay module");

  failSafe_a: assert property (@(posedge clock) disable iff (reset)
    relayPresent && !calRun && alarm1 |=> !relayLvl1)
    else $error("relay not de-energised on alarm");

  flowFault_a: assert property (@(posedge clock) disable iff (reset)
    flow < FLOW_FAULT_MLMIN && !ctrl[CTRL_PUMP_ADJ] |=> flowFault && flowWarn)
    else $error("low flow not flagged");

  pumpAdj_a: assert property (@(posedge clock) disable iff (reset)
    ctrl[CTRL_PUMP_ADJ] |=> maintSignal && !flowFault)
    else $error("pump adjust without maintenance signal");

  calHold_a: assert property (@(posedge clock) disable iff (reset)
    relayPresent && calRun && !ctrl[CTRL_TEST1] && !ctrl[CTRL_TEST2] && !ctrl[CTRL_TESTF]
    && $past(relayPresent) |=> $stable(relayLvl1) && $stable(relayFault))
    else $error("relay switched during calibration");

  testForce_a: assert property (@(posedge clock) disable iff (reset)
    relayPresent && ctrl[CTRL_TEST2] |=> !relayLvl2 && digAlarm[1])
    else $error("test mode did not force alarm");

  ackBlock_a: assert property (@(posedge clock) disable iff (reset)
    ctrl[CTRL_ACK_DIS] |-> !ackPulse)
    else $error("acknowledge passed while disabled");

  covAlarm: cover property (@(posedge clock) disable iff (reset) relayPresent && !relayLvl1);
  covSpanAuto: cover property (@(posedge clock) disable iff (reset) calState == CAL_SPAN ##1 calState == CAL_DONE);
  covIrq: cover property (@(posedge clock) disable iff (reset) irq);

endmodule // gatr_core

/* hw/gatr_level.sv */
// One alarm level: threshold with direction, hysteresis, latching and acknowledge.
// Assumes conc and the config come from the same clock domain.
`timescale 1ns/10ps
module gatr_level
  import gatr_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [CONC_W-1:0] conc,
  input wire logic [CONC_W-1:0] setPoint,
  input wire logic [CONC_W-1:0] hyst,
  input wire logic falling,
  input wire logic latching,
  input wire logic ackable,
  input wire logic ackPulse,
  output logic tripped,
  output logic active
);

  logic [CONC_W:0] releaseLow;
  logic [CONC_W:0] releaseHigh;
  logic reached;
  logic released;
  logic next_tripped;

  // Release points widened by one bit to avoid wrap
  assign releaseLow = {1'b0, setPoint} - {1'b0, hyst};
  assign releaseHigh = {1'b0, setPoint} + {1'b0, hyst};

  // ----------------------------------------------------------------
  // Condition with hysteresis
  // ----------------------------------------------------------------
  always_comb
  begin
    reached = falling ? (conc <= setPoint) : (conc >= setPoint);
    if (falling)
      released = {1'b0, conc} > releaseHigh;
    else
      released = releaseLow[CONC_W] ? 1'b0 : ({1'b0, conc} < releaseLow);
    next_tripped = tripped ? !released : reached;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      tripped <= 1'b0;
    else
      tripped <= next_tripped;
  end

  // ----------------------------------------------------------------
  // Relay state: latching and acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
      active <= 1'b0;
    else if (next_tripped && !tripped)
      active <= 1'b1;
    else if (next_tripped)
    begin
      if (ackPulse && ackable)
        active <= 1'b0;
      // Non-ackable: acknowledge ignored while condition holds
    end
    else if (!latching)
      active <= 1'b0;
    else if (ackPulse)
      active <= 1'b0;
  end

  covLatchHeld: cover property (@(posedge clock) disable iff (reset) active && !tripped && latching);

  latchHold_a: assert property (@(posedge clock) disable iff (reset)
    active && !tripped && latching && !ackPulse |=> active)
    else $error("latched alarm released without acknowledge");

  nonLatch_a: assert property (@(posedge clock) disable iff (reset)
    active && !next_tripped && !latching |=> !active)
    else $error("non-latching alarm failed to release");

  ackClear_a: assert property (@(posedge clock) disable iff (reset)
    active && tripped && next_tripped && ackable && ackPulse |=> !active)
    else $error("acknowledge did not clear alarm");

  noAck_a: assert property (@(posedge clock) disable iff (reset)
    active && tripped && next_tripped && !ackable |=> active)
    else $error("non-acknowledgeable alarm cleared while condition holds");

  trip_a: assert property (@(posedge clock) disable iff (reset)
    !tripped && !falling && conc >= setPoint && $stable(falling) |=> tripped)
    else $error("rising alarm did not trip at set point");

  hystHold_a: assert property (@(posedge clock) disable iff (reset)
    tripped && !falling && !releaseLow[CONC_W] && {1'b0, conc} >= releaseLow |=> tripped)
    else $error("rising alarm released inside hysteresis band");

  fallHyst_a: assert property (@(posedge clock) disable iff (reset)
    tripped && falling && {1'b0, conc} <= releaseHigh |=> tripped)
    else $error("falling alarm released inside hysteresis band");

endmodule // gatr_level

/* hw/gatr_pkg.sv */
// Package for the gas alarm threshold and relay logic.
// Assumes one 250 MHz clock; shared by the core and the alarm level module.
package gatr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CONC_W = 16;
  localparam int FLOW_W = 12;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets (word indices)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_LVL1 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_LVL2 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CFG = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CONC = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ISTAT = 4'h6;
  localparam logic [ADDR_W-1:0] REG_IMASK = 4'h7;
  localparam logic [ADDR_W-1:0] REG_ACK = 4'h8;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_MON_EN = 0;
  localparam int CTRL_ACK_DIS = 1;
  localparam int CTRL_TEST1 = 2;
  localparam int CTRL_TEST2 = 3;
  localparam int CTRL_TESTF = 4;
  localparam int CTRL_PUMP_ADJ = 5;
  localparam int CTRL_CAL_ZERO = 6;
  localparam int CTRL_CAL_SPAN = 7;
  localparam int CTRL_AUTOCAL = 8;
  localparam int CTRL_AUTOSTAB = 9;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h001;

  // Level config fields: [15:0] set point, [31:16] hysteresis
  // Config register: per level {ackable, latching, falling}
  localparam int CFG_FALL = 0;
  localparam int CFG_LATCH = 1;
  localparam int CFG_ACKABLE = 2;
  localparam logic [2:0] CFG_RESET = 3'h2;

  // Interrupt bits
  localparam int IRQ_LVL1 = 0;
  localparam int IRQ_LVL2 = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_WARN = 3;
  localparam int IRQ_CALDONE = 4;
  localparam int IRQ_W = 5;

  // ----------------------------------------------------------------
  // Flow thresholds in mL/min
  // ----------------------------------------------------------------
  localparam logic [FLOW_W-1:0] FLOW_FAULT_MLMIN = 12'h12C;
  localparam logic [FLOW_W-1:0] FLOW_WARN_MLMIN = 12'h190;

  // ----------------------------------------------------------------
  // Stability detection
  // ----------------------------------------------------------------
  localparam int STAB_TIME_MS = 10;
  localparam int CLK_MHZ = 250;
  localparam int STAB_CYCLES = STAB_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [CONC_W-1:0] STAB_BAND = 16'h0002;

  typedef enum logic [1:0]
  {
    CAL_IDLE = 2'b00,
    CAL_ZERO = 2'b01,
    CAL_SPAN = 2'b10,
    CAL_DONE = 2'b11
  } gatr_cal_e;

endpackage

/* verification/gatr_relay_model.sv */
// Model of the outboard relay module and the operator keys.
// Assumes the core's relay outputs and the bench's key requests share one clock.
`timescale 1ns/10ps
module gatr_relay_model
(
  input wire logic fitted,
  input wire logic press,
  input wire logic accept,
  input wire logic relayLvl1,
  input wire logic relayLvl2,
  input wire logic relayFault,
  input wire logic [2:0] digAlarm,
  output logic relayPresentPin,
  output logic ackKeyPin,
  output logic acceptKeyPin,
  output logic disagree
);
  logic [2:0] alarmSeen;

  assign relayPresentPin = fitted;
  assign ackKeyPin = press;
  assign acceptKeyPin = accept;
  // Open contact reads as alarm
  assign alarmSeen = fitted ? ~{relayFault, relayLvl2, relayLvl1} : 3'h0;
  assign disagree = fitted && (digAlarm !== alarmSeen);
endmodule // gatr_relay_model

/* verification/test_gatr_core.sv */
// Self-checking bench for the gas alarm core.
// Assumes gatr_core with a short stability count and the relay module model.
`timescale 1ns/10ps
module test_gatr_core
  import gatr_pkg::*;
;
  logic clock, reset, regWrite, regRead, fitted, press, accept, disagree;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, rdVal;
  logic [CONC_W-1:0] conc;
  logic [FLOW_W-1:0] flow;
  logic relayPresentPin, ackKeyPin, acceptKeyPin, relayLvl1, relayLvl2, relayFault;
  logic maintSignal, monitorWarn, flowFault, flowWarn, calZeroStep, calSpanStep, irq;
  logic [2:0] digAlarm;
  int nErrors, nCompared;

  gatr_core #(.STAB_COUNT(20)) i_dut (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .conc(conc), .flow(flow), .relayPresentPin(relayPresentPin), .ackKeyPin(ackKeyPin),
    .acceptKeyPin(acceptKeyPin), .relayLvl1(relayLvl1), .relayLvl2(relayLvl2),
    .relayFault(relayFault), .digAlarm(digAlarm), .maintSignal(maintSignal),
    .monitorWarn(monitorWarn), .flowFault(flowFault), .flowWarn(flowWarn),
    .calZeroStep(calZeroStep), .calSpanStep(calSpanStep), .irq(irq));

  gatr_relay_model i_relay (.fitted(fitted), .press(press), .accept(accept),
    .relayLvl1(relayLvl1), .relayLvl2(relayLvl2), .relayFault(relayFault),
    .digAlarm(digAlarm), .relayPresentPin(relayPresentPin), .ackKeyPin(ackKeyPin),
    .acceptKeyPin(acceptKeyPin), .disagree(disagree));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp)
    begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    tick(1);
    regWrite <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    tick(1);
    regRead <= 1'b0;
    #1;
    rdVal = regRdData;
    tick(1);
  endtask

  task automatic setConc(input logic [CONC_W-1:0] c);
    conc <= c;
    tick(4);
  endtask

  task automatic key(input logic isAccept);
    if (isAccept)
      accept <= 1'b1;
    else
      press <= 1'b1;
    tick(4);
    accept <= 1'b0;
    press <= 1'b0;
    tick(6);
  endtask

  task automatic alarms(input logic [2:0] exp);
    chk("digAlarm", {29'h0, exp}, {29'h0, digAlarm});
    chk("relays", {29'h0, ~exp}, {29'h0, relayFault, relayLvl2, relayLvl1});
    chk("disagree", 32'h0, {31'h0, disagree});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sRegs;
    rd(REG_CTRL);
    chk("ctrl", 32'h00000001, rdVal);
    rd(REG_CFG);
    chk("cfg", 32'h00000012, rdVal);
    wr(4'hF, 32'hFFFFFFFF);
    rd(4'hF);
    chk("unmapped", 32'h0, rdVal);
    alarms(3'h0);
  endtask

  task automatic sRising;
    wr(REG_LVL1, 32'h00030028);
    wr(REG_IMASK, 32'h00000001);
    setConc(16'h0027);
    alarms(3'h0);
    setConc(16'h0028);
    alarms(3'h1);
    chk("irq", 32'h1, {31'h0, irq});
    setConc(16'h0025);
    key(1'b0);
    alarms(3'h1);
    setConc(16'h0024);
    alarms(3'h1);
    key(1'b0);
    alarms(3'h0);
    wr(REG_IMASK, 32'h0);
    chk("irqMasked", 32'h0, {31'h0, irq});
    wr(REG_ISTAT, 32'h00000001);
    wr(REG_IMASK, 32'h00000001);
    chk("irqCleared", 32'h0, {31'h0, irq});
  endtask

  task automatic sFalling;
    wr(REG_CFG, 32'h0000002A);
    wr(REG_LVL2, 32'h00030014);
    setConc(16'h0015);
    alarms(3'h0);
    setConc(16'h0014);
    alarms(3'h2);
    setConc(16'h0017);
    alarms(3'h2);
    setConc(16'h0018);
    alarms(3'h0);
    setConc(16'h0014);
    key(1'b0);
    alarms(3'h0);
    setConc(16'h001E);
  endtask

  task automatic sAckDisable;
    wr(REG_CTRL, 32'h00000003);
    setConc(16'h002D);
    setConc(16'h001E);
    key(1'b0);
    alarms(3'h1);
    wr(REG_CTRL, 32'h00000001);
    key(1'b0);
    alarms(3'h0);
  endtask

  task automatic sMonitorOff;
    wr(REG_CTRL, 32'h0);
    setConc(16'h002D);
    alarms(3'h0);
    chk("monitorWarn", 32'h1, {31'h0, monitorWarn});
    setConc(16'h001E);
    key(1'b0);
    wr(REG_CTRL, 32'h00000001);
    tick(4);
    chk("monitorWarn", 32'h0, {31'h0, monitorWarn});
  endtask

  task automatic sTests;
    for (int i = 0; i < 3; i++)
    begin
      wr(REG_CTRL, 32'h00000001 | (32'h00000004 << i));
      tick(4);
      alarms(3'h1 << i);
    end
    wr(REG_CTRL, 32'h00000001);
    tick(4);
    alarms(3'h0);
  endtask

  task automatic sFlow;
    logic [FLOW_W-1:0] v [4];
    v = '{FLOW_FAULT_MLMIN, FLOW_WARN_MLMIN - 12'h001, FLOW_WARN_MLMIN, FLOW_FAULT_MLMIN - 12'h001};
    for (int i = 0; i < 4; i++)
    begin
      flow <= v[i];
      tick(4);
      chk("flowFault", {31'h0, v[i] < FLOW_FAULT_MLMIN}, {31'h0, flowFault});
      chk("flowWarn", {31'h0, v[i] < FLOW_WARN_MLMIN}, {31'h0, flowWarn});
    end
    wr(REG_CTRL, 32'h00000021);
    tick(4);
    chk("maintSignal", 32'h1, {31'h0, maintSignal});
    chk("flowFault", 32'h0, {31'h0, flowFault});
    flow <= 12'h1F4;
    wr(REG_CTRL, 32'h00000001);
    tick(4);
  endtask

  task automatic sAutocal;
    wr(REG_CTRL, 32'h00000101);
    tick(4);
    chk("zeroStep", 32'h1, {31'h0, calZeroStep});
    chk("maintSignal", 32'h1, {31'h0, maintSignal});
    setConc(16'h002D);
    // Contacts frozen, digital report still follows the alarm
    chk("relaysCal", 32'h7, {29'h0, relayFault, relayLvl2, relayLvl1});
    chk("digCal", 32'h1, {29'h0, digAlarm});
    chk("disagreeCal", 32'h1, {31'h0, disagree});
    key(1'b1);
    chk("spanStep", 32'h1, {31'h0, calSpanStep});
    chk("maintSignal", 32'h1, {31'h0, maintSignal});
    tick(40);
    rd(REG_STAT);
    chk("calState", {30'h0, CAL_DONE}, {30'h0, rdVal[8:7]});
    wr(REG_CTRL, 32'h00000001);
    tick(4);
    alarms(3'h1);
    setConc(16'h001E);
    key(1'b0);
  endtask

  task automatic sAbsent;
    fitted <= 1'b0;
    setConc(16'h002D);
    tick(4);
    chk("digAbsent", 32'h0, {29'h0, digAlarm});
    chk("relaysAbsent", 32'h0, {29'h0, relayFault, relayLvl2, relayLvl1});
    fitted <= 1'b1;
    tick(8);
    alarms(3'h1);
    setConc(16'h001E);
    key(1'b0);
    alarms(3'h0);
  endtask

  // ----------------------------------------------------------------
  // Clock, run and verdict
  // ----------------------------------------------------------------
  task automatic results;
    $display("Errors %0d, comparisons %0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    tick(6000);
    nErrors++;
    results();
  end

  initial
  begin
    reset = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = '0;
    regWrData = '0;
    conc = '0;
    flow = 12'h1F4;
    fitted = 1'b1;
    press = 1'b0;
    accept = 1'b0;
    nErrors = 0;
    nCompared = 0;
    tick(2);
    reset <= 1'b0;
    tick(4);
    wr(REG_LVL1, 32'h0000FFFF);
    wr(REG_LVL2, 32'h0000FFFF);
    key(1'b0);
    wr(REG_ISTAT, 32'h0000001F);
    sRegs();
    sRising();
    sFalling();
    sAckDisable();
    sMonitorOff();
    sTests();
    sFlow();
    sAutocal();
    sAbsent();
    results();
  end
endmodule // test_gatr_core
